// file: ctq_defs.vh
`ifndef CTQ_DEFS_VH
`define CTQ_DEFS_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CTQ_REG_CTRL 8'h00
`define CTQ_REG_DELAY 8'h04
`define CTQ_REG_LINE 8'h08
`define CTQ_REG_STAT 8'h0c
// ----------------------------------------
// control field positions
// ----------------------------------------
`define CTQ_CTRL_ON 0
`define CTQ_CTRL_SRC_LO 1
`define CTQ_CTRL_SRC_HI 2
`define CTQ_CTRL_MODE_LO 3
`define CTQ_CTRL_MODE_HI 5
`define CTQ_CTRL_POL_LO 6
`define CTQ_CTRL_POL_HI 7
`define CTQ_CTRL_OPT5 8
`define CTQ_CTRL_RST 9'h000
`define CTQ_DELAY_RST 21'h000000
`define CTQ_DELAY_MAX 21'h1e8480
// ----------------------------------------
// encodings
// ----------------------------------------
`define CTQ_SRC_LINE_A 2'h0
`define CTQ_SRC_LINE_B 2'h1
`define CTQ_SRC_CNT 2'h2
`define CTQ_MODE_RISE 3'h0
`define CTQ_MODE_FALL 3'h1
`define CTQ_MODE_BOTH 3'h2
`define CTQ_MODE_HIGH 3'h3
`define CTQ_MODE_LOW 3'h4
`define CTQ_POL_OFF 2'h0
`define CTQ_POL_READOUT 2'h1
`define CTQ_POL_EXPOSURE 2'h2
`define CTQ_LBL_IN_A 3'h1
`define CTQ_LBL_IN_B 3'h2
`define CTQ_LBL_OUT_A 3'h3
`define CTQ_LBL_OUT_B 3'h4
`define CTQ_LBL_OUT_C 3'h5
`define CTQ_LBL_NONE 3'h0
// ----------------------------------------
// timing
// ----------------------------------------
`define CTQ_CLK_HZ 20000000
`define CTQ_TICK_US 1
`define CTQ_TICK_CYC ((`CTQ_CLK_HZ / 1000000) * `CTQ_TICK_US)
// last count of the tick divider; keep equal to CTQ_TICK_CYC minus one
`define CTQ_TICK_LAST 5'h13
`endif

// file: ctq_sync.v
module ctq_sync (
  // clock
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // pin
  input wire pin_i,
  output wire lvl_o
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  reg lvl_ff;
  // change counts once stages two and three agree
  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      lvl_ff <= 1'b0;
    end else if (ce_i) begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        lvl_ff <= s3_ff;
      end
    end
  end
  assign lvl_o = lvl_ff;
endmodule

// file: ctq_us_tick.v
`include "ctq_defs.vh"
module ctq_us_tick (
  // clock
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // restart and tick
  input wire clr_i,
  output wire tick_o
);
  reg [4:0] cnt_ff;
  wire wrap;
  assign wrap = (cnt_ff == `CTQ_TICK_LAST);
  // one-microsecond tick, restarted when a delay starts
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 5'h00;
    end else if (ce_i) begin
      if (clr_i || wrap) begin
        cnt_ff <= 5'h00;
      end else begin
        cnt_ff <= cnt_ff + 5'h01;
      end
    end
  end
  assign tick_o = wrap & ~clr_i;
endmodule

// file: ctq_trigger.v
// The implementer's own choices: the address map and the Wishbone register port.
`include "ctq_defs.vh"
module ctq_trigger (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // trigger inputs (already through the inverter)
  input wire in_line_a_i,
  input wire in_line_b_i,
  input wire cnt_one_done_i,
  // frame state from the sensor timing
  input wire exposing_i,
  input wire reading_i,
  // trigger event
  output wire trig_fire_o,
  output wire trig_busy_o
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_HOLD = 2'h2;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [8:0] ctrl_ff;
  reg [20:0] trig_wait_us_ff;
  reg [2:0] line_index_sel_ff;
  reg [31:0] dat_ff;
  reg ack_ff;
  reg [1:0] st_ff;
  reg [20:0] dly_ff;
  reg fire_ff;
  reg latched_ff;
  reg prev_ff;
  reg refused_ff;
  reg exp_d_ff;
  reg busy_ff;

  wire trig_on_off;
  wire [1:0] src_sel;
  wire [2:0] trig_qualify_mode;
  wire [1:0] trig_accept_policy;
  wire opt_out_c;
  assign trig_on_off = ctrl_ff[`CTQ_CTRL_ON];
  assign src_sel = ctrl_ff[`CTQ_CTRL_SRC_HI:`CTQ_CTRL_SRC_LO];
  assign trig_qualify_mode = ctrl_ff[`CTQ_CTRL_MODE_HI:`CTQ_CTRL_MODE_LO];
  assign trig_accept_policy = ctrl_ff[`CTQ_CTRL_POL_HI:`CTQ_CTRL_POL_LO];
  assign opt_out_c = ctrl_ff[`CTQ_CTRL_OPT5];

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  wire lvl_a;
  wire lvl_b;
  ctq_sync u_sync_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(in_line_a_i),
    .lvl_o(lvl_a)
  );
  ctq_sync u_sync_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(in_line_b_i),
    .lvl_o(lvl_b)
  );

  // ----------------------------------------
  // line labels
  // ----------------------------------------
  reg [2:0] line_label;
  always @* begin
    case (line_index_sel_ff)
      3'h1: line_label = `CTQ_LBL_IN_A;
      3'h2: line_label = `CTQ_LBL_IN_B;
      3'h3: line_label = `CTQ_LBL_OUT_A;
      3'h4: line_label = `CTQ_LBL_OUT_B;
      3'h5: line_label = opt_out_c ? `CTQ_LBL_OUT_C : `CTQ_LBL_NONE;
      default: line_label = `CTQ_LBL_NONE;
    endcase
  end
  wire line_is_out;
  assign line_is_out = (line_label >= `CTQ_LBL_OUT_A);

  // ----------------------------------------
  // qualification
  // ----------------------------------------
  wire src_is_line;
  wire line_lvl;
  assign src_is_line = (src_sel == `CTQ_SRC_LINE_A) || (src_sel == `CTQ_SRC_LINE_B);
  assign line_lvl = (src_sel == `CTQ_SRC_LINE_B) ? lvl_b : lvl_a;

  reg qual;
  always @* begin
    qual = 1'b0;
    if (!src_is_line) begin
      qual = (src_sel == `CTQ_SRC_CNT) & cnt_one_done_i;
    end else begin
      case (trig_qualify_mode)
        `CTQ_MODE_RISE: qual = line_lvl & ~prev_ff;
        `CTQ_MODE_FALL: qual = ~line_lvl & prev_ff;
        `CTQ_MODE_BOTH: qual = line_lvl ^ prev_ff;
        `CTQ_MODE_HIGH: qual = line_lvl;
        `CTQ_MODE_LOW: qual = ~line_lvl;
        default: qual = 1'b0;
      endcase
    end
  end
  wire valid_trig;
  assign valid_trig = trig_on_off & qual;

  // ----------------------------------------
  // overlap policy
  // ----------------------------------------
  // a level trigger is only taken when the block is free, so it does not retrigger
  // mid-delay; busy covers the frame from the cycle after the fire until its exposure ends
  reg accept;
  always @* begin
    case (trig_accept_policy)
      `CTQ_POL_OFF: accept = ~exposing_i & ~reading_i;
      `CTQ_POL_READOUT: accept = ~exposing_i;
      `CTQ_POL_EXPOSURE: accept = ~exposing_i;
      default: accept = ~exposing_i & ~reading_i;
    endcase
  end
  wire exp_end;
  assign exp_end = exp_d_ff & ~exposing_i;
  wire take;
  // busy only rises the cycle after a fire, so the fire itself blocks a retake
  assign take = valid_trig & accept & (st_ff == ST_IDLE) & ~busy_ff & ~fire_ff;

  // ----------------------------------------
  // delay and fire
  // ----------------------------------------
  wire tick;
  reg tick_clr;
  ctq_us_tick u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clr_i(tick_clr),
    .tick_o(tick)
  );
  always @* begin
    tick_clr = take;
  end

  // postponement: exposure may not finish before the previous readout does
  wire hold_needed;
  assign hold_needed = (trig_accept_policy == `CTQ_POL_EXPOSURE) & reading_i;
  wire qual_is_level;
  assign qual_is_level = src_is_line &
    ((trig_qualify_mode == `CTQ_MODE_HIGH) || (trig_qualify_mode == `CTQ_MODE_LOW));

  always @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= ST_IDLE;
      dly_ff <= `CTQ_DELAY_RST;
      fire_ff <= 1'b0;
      latched_ff <= 1'b0;
      prev_ff <= 1'b0;
      refused_ff <= 1'b0;
      exp_d_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else if (ce_i) begin
      prev_ff <= line_lvl;
      exp_d_ff <= exposing_i;
      fire_ff <= 1'b0;
      if (fire_ff) begin
        busy_ff <= 1'b1;
      end else if (exp_end || (!exposing_i && !reading_i)) begin
        busy_ff <= 1'b0;
      end
      if (valid_trig && !take && !qual_is_level) begin
        refused_ff <= 1'b1;
      end
      case (st_ff)
        ST_IDLE: begin
          if (take) begin
            if (trig_wait_us_ff == 21'h000000) begin
              if (hold_needed) begin
                latched_ff <= 1'b1;
                st_ff <= ST_HOLD;
              end else begin
                fire_ff <= 1'b1;
              end
            end else begin
              dly_ff <= trig_wait_us_ff;
              st_ff <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (tick) begin
            dly_ff <= dly_ff - 21'h000001;
            if (dly_ff == 21'h000001) begin
              if (hold_needed) begin
                latched_ff <= 1'b1;
                st_ff <= ST_HOLD;
              end else begin
                fire_ff <= 1'b1;
                st_ff <= ST_IDLE;
              end
            end
          end
        end
        ST_HOLD: begin
          if (!reading_i) begin
            latched_ff <= 1'b0;
            fire_ff <= 1'b1;
            st_ff <= ST_IDLE;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  wire req;
  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  reg [31:0] rd_mux;
  always @* begin
    case (wb_adr_i)
      `CTQ_REG_CTRL: rd_mux = {23'h000000, ctrl_ff};
      `CTQ_REG_DELAY: rd_mux = {11'h000, trig_wait_us_ff};
      `CTQ_REG_LINE: rd_mux = {25'h0000000, line_is_out, line_label, line_index_sel_ff};
      `CTQ_REG_STAT: rd_mux = {26'h0000000, refused_ff, latched_ff, busy_ff, lvl_b, lvl_a,
        (st_ff != ST_IDLE)};
      default: rd_mux = 32'h00000000;
    endcase
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= `CTQ_CTRL_RST;
      trig_wait_us_ff <= `CTQ_DELAY_RST;
      line_index_sel_ff <= 3'h1;
      dat_ff <= 32'h00000000;
      ack_ff <= 1'b0;
    end else if (ce_i) begin
      ack_ff <= req;
      if (req) begin
        dat_ff <= rd_mux;
      end
      if (req && wb_we_i) begin
        if (wb_adr_i == `CTQ_REG_CTRL) begin
          if (wb_sel_i[0]) begin
            ctrl_ff[7:0] <= wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            ctrl_ff[8] <= wb_dat_i[8];
          end
        end
        if (wb_adr_i == `CTQ_REG_DELAY && (&wb_sel_i[2:0])) begin
          if (wb_dat_i[20:0] > `CTQ_DELAY_MAX) begin
            trig_wait_us_ff <= `CTQ_DELAY_MAX;
          end else begin
            trig_wait_us_ff <= wb_dat_i[20:0];
          end
        end
        if (wb_adr_i == `CTQ_REG_LINE && wb_sel_i[0]) begin
          line_index_sel_ff <= wb_dat_i[2:0];
        end
      end
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign trig_fire_o = fire_ff;
  assign trig_busy_o = busy_ff;
endmodule

// file: ctq_frame_model.sv
// ------
// sensor timing seen by the trigger block
// ------
module ctq_frame_model #(
  parameter int EXP = 30,
  parameter int RD = 60
) (
  // clock
  input wire clk_i,
  input wire rst_i,
  // frame control
  input wire trig_fire_i,
  output wire exposing_o,
  output wire reading_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int exp_n;
  int rd_n;
  assign exposing_o = (exp_n != 0);
  assign reading_o = (rd_n != 0);
  // readout of one frame may run on while the next exposure starts
  always @(posedge clk_i) begin
    if (rst_i) begin
      exp_n <= 0;
      rd_n <= 0;
    end else begin
      exp_n <= trig_fire_i ? EXP : exp_n - (exp_n != 0);
      if (exp_n == 1)
        rd_n <= RD;
      else if (rd_n != 0)
        rd_n <= rd_n - 1;
    end
  end
endmodule

// file: ctq_trigger_monitor.sv
`include "ctq_defs.vh"
module ctq_trigger_monitor (
  // clock
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // trigger
  input wire in_line_a_i,
  input wire in_line_b_i,
  input wire cnt_one_done_i,
  input wire exposing_i,
  input wire reading_i,
  input wire trig_fire_o,
  input wire trig_busy_o
);
  // ------
  // shadow of the settings, taken at the ack edge, one cycle after the design takes them
  // ------
  logic [7:0] cfg_ff;
  logic dz_ff;
  wire on_w = cfg_ff[0];
  wire [1:0] src_w = cfg_ff[2:1];
  wire [2:0] md_w = cfg_ff[5:3];
  wire [1:0] pol_w = cfg_ff[7:6];
  wire free_w = dz_ff && !trig_busy_o && !exposing_i && !reading_i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ff <= 8'h00;
      dz_ff <= 1'h1;
    end else if (wb_ack_o && wb_we_i) begin
      if (wb_adr_i == `CTQ_REG_CTRL && wb_sel_i[0])
        cfg_ff <= wb_dat_i[7:0];
      if (wb_adr_i == `CTQ_REG_DELAY && &wb_sel_i[2:0])
        dz_ff <= ~|wb_dat_i[20:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_edge;
    on_w && src_w == `CTQ_SRC_LINE_A && free_w && ((md_w == `CTQ_MODE_RISE && $rose(in_line_a_i))
      || (md_w == `CTQ_MODE_FALL && $fell(in_line_a_i))
      || (md_w == `CTQ_MODE_BOTH && $changed(in_line_a_i)));
  endsequence
  property p_ack; s_req |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack not a single cycle after request");
  property p_edge; s_edge |-> ##[2:8] trig_fire_o; endproperty
  a_edge: assert property (p_edge) else $error("line edge not fired");
  property p_cnt;
    on_w && src_w == `CTQ_SRC_CNT && free_w && cnt_one_done_i |-> ##[1:2] trig_fire_o;
  endproperty
  a_cnt: assert property (p_cnt) else $error("counter end not fired");
  property p_offsw; !on_w && !$past(on_w, 3) |-> !trig_fire_o; endproperty
  a_offsw: assert property (p_offsw) else $error("fire while switched off");
  property p_poff;
    pol_w == `CTQ_POL_OFF && dz_ff && trig_fire_o |-> !$past(exposing_i || reading_i);
  endproperty
  a_poff: assert property (p_poff) else $error("fire taken during frame");
  property p_pro;
    pol_w == `CTQ_POL_READOUT && dz_ff && trig_fire_o |-> !$past(exposing_i);
  endproperty
  a_pro: assert property (p_pro) else $error("fire taken during exposure");
  property p_pexp;
    pol_w == `CTQ_POL_EXPOSURE && trig_fire_o |-> !reading_i && !exposing_i;
  endproperty
  a_pexp: assert property (p_pexp) else $error("latched fire not postponed");
  property p_busy; trig_busy_o |-> !trig_fire_o; endproperty
  a_busy: assert property (p_busy) else $error("fire while busy");
  property p_pulse; trig_fire_o |=> !trig_fire_o; endproperty
  a_pulse: assert property (p_pulse) else $error("fire longer than one cycle");
endmodule
bind ctq_trigger ctq_trigger_monitor i_ctq_trigger_monitor (.clk_i, .rst_i, .ce_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .in_line_a_i,
  .in_line_b_i, .cnt_one_done_i, .exposing_i, .reading_i, .trig_fire_o, .trig_busy_o);

// file: ctq_trigger_bench.sv
`include "ctq_defs.vh"
module ctq_trigger_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc = 1'h0;
  logic we = 1'h0;
  logic la = 1'h0;
  logic lb = 1'h0;
  logic cnt = 1'h0;
  logic ce = 1'h1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  wire [31:0] dat_o;
  wire ack, fire, busy, expo, rdg;
  int error_cnt = 0;
  int checked = 0;
  int fire_n = 0;
  int mark = 0;
  int gap[4] = '{9, 39, 119, 130};
  ctq_trigger i_ctq_trigger (.clk_i, .rst_i, .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .in_line_a_i(la), .in_line_b_i(lb), .cnt_one_done_i(cnt),
    .exposing_i(expo), .reading_i(rdg), .trig_fire_o(fire), .trig_busy_o(busy));
  ctq_frame_model i_ctq_frame_model (.clk_i, .rst_i, .trig_fire_i(fire), .exposing_o(expo),
    .reading_o(rdg));
  always #25 clk_i = ~clk_i;
  // non-blocking so readers at the same edge see a settled count
  always @(posedge clk_i) if (fire === 1'h1) fire_n <= fire_n + 1;
  // ------
  // tasks
  // ------
  task automatic test_done;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic bad(input string m);
    error_cnt++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) bad("register value");
  endtask
  task automatic chk_rng(input int g, input int lo, input int hi);
    checked++;
    if (g < lo || g > hi) bad("event count or delay");
  endtask
  task automatic cyc_w(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk_i);
    cyc <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'h1 && n < 20);
    rdat = dat_o;
    cyc <= 1'h0;
    we <= 1'h0;
    if (n >= 20) begin
      bad("no ack");
      test_done;
    end
  endtask
  task automatic pulse;
    cnt <= 1'h1;
    cyc_w(1);
    cnt <= 1'h0;
  endtask
  // one high and one low phase of both lines, a counter end in each
  task automatic run_cfg(input logic on, input logic [1:0] s, input logic [2:0] m, input int l1,
    input int h1, input int l2, input int h2);
    int c[3];
    wb(1'h1, `CTQ_REG_CTRL, {`CTQ_POL_READOUT, m, s, on}, 4'hf);
    cyc_w(200);
    for (int p = 0; p < 2; p++) begin
      la <= (p == 0);
      lb <= (p == 0);
      // count from 6 cycles on: takes the edge fire, not a level fire from before
      cyc_w(6);
      c[p] = fire_n;
      cyc_w(114);
      pulse;
      cyc_w(79);
    end
    cyc_w(6);
    c[2] = fire_n;
    chk_rng(c[1] - c[0], l1, h1);
    chk_rng(c[2] - c[1], l2, h2);
  endtask
  // counter ends at 0, 10, 50 and 170 cycles against a 30 + 60 cycle frame
  task automatic run_pol(input logic [1:0] p, input int e);
    int s;
    wb(1'h1, `CTQ_REG_CTRL, {p, `CTQ_MODE_RISE, `CTQ_SRC_CNT, 1'h1}, 4'hf);
    cyc_w(200);
    s = fire_n;
    foreach (gap[i]) begin
      pulse;
      cyc_w(gap[i]);
    end
    chk_rng(fire_n - s, e, e);
  endtask
  task automatic run_dly(input int d);
    int n;
    int s;
    wb(1'h1, `CTQ_REG_DELAY, d, 4'hf);
    cyc_w(200);
    s = fire_n;
    pulse;
    n = 0;
    while (fire_n == s && n < 300) begin
      cyc_w(1);
      n++;
    end
    chk_rng(n, d * `CTQ_TICK_CYC + 1, d * `CTQ_TICK_CYC + 4);
    if (n >= 300) test_done;
  endtask
  // ------
  // tests
  // ------
  initial begin
    cyc_w(4);
    rst_i <= 1'h0;
    wb(1'h0, `CTQ_REG_CTRL, 32'h0, 4'hf);
    chk_val(rdat, `CTQ_CTRL_RST);
    wb(1'h0, `CTQ_REG_LINE, 32'h0, 4'hf);
    chk_val(rdat, {`CTQ_LBL_IN_A, 3'h1});
    wb(1'h1, `CTQ_REG_CTRL, 32'h15b, 4'hf);
    for (int i = 1; i <= 5; i++) begin
      wb(1'h1, `CTQ_REG_LINE, i, 4'hf);
      wb(1'h0, `CTQ_REG_LINE, 32'h0, 4'hf);
      chk_val(rdat, {i > 2, 3'(i), 3'(i)});
    end
    wb(1'h1, `CTQ_REG_DELAY, 32'h3fffff, 4'hf);
    wb(1'h1, `CTQ_REG_DELAY, 32'h0, 4'h1);
    wb(1'h0, `CTQ_REG_DELAY, 32'h0, 4'hf);
    chk_val(rdat, `CTQ_DELAY_MAX);
    wb(1'h0, 8'h10, 32'h0, 4'hf);
    chk_val(rdat, 32'h0);
    wb(1'h1, `CTQ_REG_DELAY, 32'h0, 4'hf);
    $display("register test done");
    run_cfg(1'h1, `CTQ_SRC_LINE_A, `CTQ_MODE_RISE, 1, 1, 0, 0);
    run_cfg(1'h1, `CTQ_SRC_LINE_A, `CTQ_MODE_FALL, 0, 0, 1, 1);
    run_cfg(1'h1, `CTQ_SRC_LINE_A, `CTQ_MODE_BOTH, 1, 1, 1, 1);
    run_cfg(1'h1, `CTQ_SRC_LINE_B, `CTQ_MODE_RISE, 1, 1, 0, 0);
    run_cfg(1'h1, `CTQ_SRC_CNT, `CTQ_MODE_FALL, 1, 1, 1, 1);
    run_cfg(1'h1, `CTQ_SRC_LINE_A, `CTQ_MODE_HIGH, 2, 12, 0, 0);
    run_cfg(1'h1, `CTQ_SRC_LINE_A, `CTQ_MODE_LOW, 0, 0, 2, 12);
    run_cfg(1'h0, `CTQ_SRC_CNT, `CTQ_MODE_FALL, 0, 0, 0, 0);
    // fifth output not fitted once the ctrl writes above cleared it
    wb(1'h0, `CTQ_REG_LINE, 32'h0, 4'hf);
    chk_val(rdat, 32'h5);
    $display("source and mode test done");
    run_pol(`CTQ_POL_OFF, 2);
    wb(1'h0, `CTQ_REG_STAT, 32'h0, 4'hf);
    chk_val(rdat & 32'h20, 32'h20);
    run_pol(`CTQ_POL_READOUT, 3);
    run_pol(`CTQ_POL_EXPOSURE, 3);
    $display("overlap test done");
    run_dly(0);
    run_dly(3);
    // clock enable low for 40 cycles stretches a running delay by 40
    cyc_w(200);
    mark = fire_n;
    pulse;
    cyc_w(10);
    ce <= 1'h0;
    cyc_w(40);
    ce <= 1'h1;
    cyc_w(40);
    chk_rng(fire_n - mark, 0, 0);
    cyc_w(50);
    chk_rng(fire_n - mark, 1, 1);
    $display("delay test done");
    test_done;
  end
endmodule
